// [hdl/mivp_pkg.sv]
// constants, tables and carrier types for the maskable interrupt controller
package mivp_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int MIVP_NSRC = 18;
  localparam int MIVP_NPIN = 4;
  localparam int MIVP_VEC_BYTES = 4;
  localparam int MIVP_VTAB_BYTES = 256;

  // ----------------------------------------------------------------
  // register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] MIVP_OFF_VBASE0 = 8'h60;
  localparam logic [7:0] MIVP_OFF_VBASE1 = 8'h61;
  localparam logic [7:0] MIVP_OFF_VBASE2 = 8'h62;
  localparam logic [7:0] MIVP_OFF_PINEN = 8'h63;
  localparam int MIVP_LVL_MSB = 2;
  localparam int MIVP_IR_BIT = 3;
  localparam int MIVP_POL_BIT = 4;
  localparam int MIVP_BOTH_LSB = 4;
  localparam logic [2:0] MIVP_LVL_RST = 3'h0;
  localparam logic [19:0] MIVP_VBASE_RST = 20'h00000;
  localparam logic [7:0] MIVP_PINEN_RST = 8'h00;

  // ----------------------------------------------------------------
  // per-source tables, index order is ascending interrupt number
  // ----------------------------------------------------------------
  // R03 R04 R05 R06 R07
  localparam logic [5:0] MIVP_SRC_NUM [0:MIVP_NSRC-1] = '{
    6'h01, 6'h02, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h10, 6'h11, 6'h12,
    6'h15, 6'h16, 6'h18, 6'h19, 6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h1f};
  localparam logic [7:0] MIVP_SRC_OFF [0:MIVP_NSRC-1] = '{
    8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48,
    8'h55, 8'h49, 8'h4a, 8'h59, 8'h4b, 8'h4c, 8'h5d, 8'h5e, 8'h4d};
  // {is_pin, pin index}; pin index 0..3 stands for pins 0, 1, 2 and 4
  localparam logic [2:0] MIVP_SRC_PIN [0:MIVP_NSRC-1] = '{
    3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
    3'h6, 3'h0, 3'h0, 3'h5, 3'h0, 3'h0, 3'h4, 3'h7, 3'h0};

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mivp_bus_t;

  typedef struct packed {
    logic req;
    logic [5:0] num;
    logic [2:0] level;
    logic [19:0] vector;
  } mivp_irq_t;

  typedef struct packed {
    logic valid;
    logic [19:0] vector;
  } mivp_swv_t;

  // offset stays inside the 256-byte table, added to the base
  function automatic logic [19:0] mivp_vec_addr(input logic [19:0] base, input logic [5:0] num);
    logic [7:0] off;
    off = 8'(num) * 8'(MIVP_VEC_BYTES);
    return base + {12'h000, off};
  endfunction : mivp_vec_addr

endpackage : mivp_pkg

// [hdl/mivp_pin_edge.sv]
// pin synchronisers and edge selection for the external interrupt pins
`timescale 1ns/1ns
module mivp_pin_edge (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] pin_in,
  input wire logic [3:0] edge_polarity_sel,
  input wire logic [3:0] both,
  input wire logic [3:0] en,
  output logic [3:0] pulse
);

  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] last_lvl_reg;
  logic [3:0] last_sel_reg;
  logic [3:0] sel;

  // ----------------------------------------------------------------
  // per-pin edge logic
  // ----------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 4; p++)
    begin : g_pin
      // rising edge of the polarity-adjusted level; a polarity rewrite
      // flips sel and may raise one spurious request, which is accepted
      assign sel[p] = sync2_reg[p] ^ ~edge_polarity_sel[p]; // R11 R13
      assign pulse[p] = en[p] & (both[p] ? (sync2_reg[p] ^ last_lvl_reg[p]) : (sel[p] & ~last_sel_reg[p]));

      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          sync1_reg[p] <= 1'b0;
          sync2_reg[p] <= 1'b0;
          last_lvl_reg[p] <= 1'b0;
          last_sel_reg[p] <= 1'b0;
        end
        else
        begin
          sync1_reg[p] <= pin_in[p];
          sync2_reg[p] <= sync1_reg[p];
          last_lvl_reg[p] <= sync2_reg[p];
          last_sel_reg[p] <= sel[p];
        end
      end

      a_rise_detect: assert property (@(posedge clk) disable iff (reset) // R11
        (en[p] && !both[p] && edge_polarity_sel[p] && $past(edge_polarity_sel[p]) && sync2_reg[p] && !$past(sync2_reg[p]))
        |-> pulse[p])
        else $error("pin edge missed");
    end
  endgenerate

endmodule : mivp_pin_edge

// [hdl/mivp_irq_ctrl.sv]
// maskable interrupt controller: control registers, acceptance, priority, vectors
`timescale 1ns/1ns

// Behaviour
// R01: vector table spans 256 bytes from base
// R02: vector offsets add to base register
// R03: number n vector at offset 4n
// R04: timer e, serial2, keypad numbers 10-13
// R05: serial0 17,18; compare b 16; timer a 22
// R06: pins 29,30,21,25; timers, compares, capture mapped
// R07: numbers 32-63 software only; reserved unmapped
// R08: break and software ignore global enable
// R09: masking logic covers maskable sources only
// R10: level b2-b0, request b3, polarity b4
// R11: polarity 0 falling, 1 rising edge
// R12: software keeps polarity 0 in both-edge mode
// R13: polarity rewrite may set request flag
// R14: software rewrites control only while quiet
// R15: global enable 0 blocks all maskable
// R16: request sets flag, acknowledge clears it
// R17: writing 0 clears flag, 1 ignored
// R18: accept when enabled, requested, level above priority
// R19: enable, flags, levels, priority kept independent
// R20: level 0 disables, 7 highest
// R21: processor priority 7 blocks all
// R22: equal levels resolved to one winner
// R23: lower number wins ties; report number, level
module mivp_irq_ctrl (
  input wire logic clk,
  input wire logic reset,
  input mivp_pkg::mivp_bus_t bus,
  output logic [7:0] rd_data,
  input wire logic [17:0] periph_req,
  input wire logic [3:0] pin_in,
  input wire logic cpu_i_flag,
  input wire logic [2:0] cpu_ipl,
  input wire logic cpu_ack,
  input wire logic sw_int,
  input wire logic [5:0] sw_num,
  output mivp_pkg::mivp_irq_t irq_o,
  output mivp_pkg::mivp_swv_t sw_vec_o
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  localparam int NSRC = mivp_pkg::MIVP_NSRC;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [2:0] lvl_reg [NSRC];
  logic [2:0] lvl_next [NSRC];
  logic [NSRC-1:0] ir_reg;
  logic [NSRC-1:0] ir_next;
  logic [NSRC-1:0] pol_reg;
  logic [NSRC-1:0] pol_next;
  logic [19:0] vbase_reg;
  logic [7:0] pinen_reg;
  logic [7:0] rd_data_reg;

  logic irq_req_reg;
  logic [4:0] irq_idx_reg;
  logic [5:0] irq_num_reg;
  logic [2:0] irq_lvl_reg;
  logic [19:0] irq_vec_reg;
  logic sw_valid_reg;
  logic [19:0] sw_vec_reg;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [NSRC-1:0] wr_sel;
  logic [NSRC-1:0] rd_sel;
  logic [NSRC-1:0] src_set;
  logic [NSRC-1:0] ack_clr;
  logic [NSRC-1:0] eligible;
  logic [7:0] src_byte [NSRC];
  logic [3:0] pin_pol;
  logic [3:0] pin_pulse;
  logic wr_vb0;
  logic wr_vb1;
  logic wr_vb2;
  logic wr_pinen;
  logic irq_taken;
  logic [7:0] rd_mux;

  assign wr_vb0 = bus.wr && (bus.addr == mivp_pkg::MIVP_OFF_VBASE0);
  assign wr_vb1 = bus.wr && (bus.addr == mivp_pkg::MIVP_OFF_VBASE1);
  assign wr_vb2 = bus.wr && (bus.addr == mivp_pkg::MIVP_OFF_VBASE2);
  assign wr_pinen = bus.wr && (bus.addr == mivp_pkg::MIVP_OFF_PINEN);
  assign irq_taken = cpu_ack && irq_req_reg;

  // ----------------------------------------------------------------
  // pin edge detection
  // ----------------------------------------------------------------
  mivp_pin_edge u_mivp_pin_edge (
    .clk(clk),
    .reset(reset),
    .pin_in(pin_in),
    .edge_polarity_sel(pin_pol),
    .both(pinen_reg[7:mivp_pkg::MIVP_BOTH_LSB]),
    .en(pinen_reg[mivp_pkg::MIVP_BOTH_LSB-1:0]),
    .pulse(pin_pulse)
  );

  // ----------------------------------------------------------------
  // per-source control registers
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NSRC; i++)
    begin : g_src
      localparam logic [2:0] PIN = mivp_pkg::MIVP_SRC_PIN[i];

      assign wr_sel[i] = bus.wr && (bus.addr == mivp_pkg::MIVP_SRC_OFF[i]);
      assign rd_sel[i] = bus.rd && (bus.addr == mivp_pkg::MIVP_SRC_OFF[i]);
      assign ack_clr[i] = irq_taken && (irq_idx_reg == 5'(i)); // R16

      if (PIN[2])
      begin : g_pin
        assign src_set[i] = pin_pulse[PIN[1:0]];
        assign pin_pol[PIN[1:0]] = pol_reg[i];
        assign pol_next[i] = wr_sel[i] ? bus.wdata[mivp_pkg::MIVP_POL_BIT] : pol_reg[i]; // R10
      end
      else
      begin : g_per
        assign src_set[i] = periph_req[i];
        assign pol_next[i] = 1'b0;
      end

      // set wins over a software clear and over an acknowledge
      assign ir_next[i] = src_set[i] |
                          (ir_reg[i] & ~(wr_sel[i] & ~bus.wdata[mivp_pkg::MIVP_IR_BIT]) & ~ack_clr[i]); // R16 R17
      assign lvl_next[i] = wr_sel[i] ? bus.wdata[mivp_pkg::MIVP_LVL_MSB:0] : lvl_reg[i]; // R10 R19
      // level 0 never exceeds any priority, level 7 never passes priority 7
      assign eligible[i] = cpu_i_flag && ir_next[i] && (lvl_next[i] > cpu_ipl); // R15 R18 R20 R21
      assign src_byte[i] = {3'h0, pol_reg[i], ir_reg[i], lvl_reg[i]}; // R10

      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          lvl_reg[i] <= mivp_pkg::MIVP_LVL_RST;
          ir_reg[i] <= 1'b0;
          pol_reg[i] <= 1'b0;
        end
        else
        begin
          lvl_reg[i] <= lvl_next[i];
          ir_reg[i] <= ir_next[i];
          pol_reg[i] <= pol_next[i];
        end
      end

      a_set_wins: assert property (src_set[i] |=> ir_reg[i]) // R16
        else $error("request flag lost its set");
      a_sw_clear: assert property (wr_sel[i] && !bus.wdata[mivp_pkg::MIVP_IR_BIT] && !src_set[i] // R17
        |=> !ir_reg[i])
        else $error("write of zero did not clear flag");
      a_no_write_one: assert property (wr_sel[i] && !ir_reg[i] && !src_set[i] |=> !ir_reg[i]) // R17
        else $error("software write set a request flag");
      a_ack_clears: assert property (ack_clr[i] && !src_set[i] |=> !ir_reg[i]) // R16
        else $error("acknowledge did not clear flag");
      a_lvl_hold: assert property (!wr_sel[i] |=> lvl_reg[i] == $past(lvl_reg[i])) // R19
        else $error("level changed without a write");
      a_ir_hold: assert property (!src_set[i] && !wr_sel[i] && !ack_clr[i] |=> // R19
        ir_reg[i] == $past(ir_reg[i]))
        else $error("request flag changed on its own");
      a_rd_mapped: assert property (rd_sel[i] |=> // R10
        rd_data[7:5] == 3'h0 && rd_data[3] == $past(ir_reg[i]))
        else $error("control byte read wrong");
      a_tie_order: assert property (eligible[i] |=> irq_o.req && // R22 R23
        ((irq_o.level > $past(lvl_next[i])) ||
         ((irq_o.level == $past(lvl_next[i])) && (irq_idx_reg <= 5'(i)))))
        else $error("priority winner wrong");
    end
  endgenerate

  // ----------------------------------------------------------------
  // priority resolution
  // ----------------------------------------------------------------
  logic win_found;
  logic [4:0] win_idx;
  logic [2:0] win_lvl;

  // scanning downward with >= lets the lower number take an equal level
  always_comb
  begin
    win_found = 1'b0;
    win_idx = 5'h00;
    win_lvl = 3'h0;
    for (int k = NSRC - 1; k >= 0; k--)
    begin
      if (eligible[k] && (lvl_next[k] >= win_lvl))
      begin
        win_found = 1'b1; // R22
        win_idx = 5'(k); // R23
        win_lvl = lvl_next[k];
      end
    end
  end

  // selection works on next-state flags so an acknowledged source
  // never shows for a second cycle after its flag is cleared
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      irq_req_reg <= 1'b0;
      irq_idx_reg <= 5'h00;
      irq_num_reg <= 6'h00;
      irq_lvl_reg <= 3'h0;
      irq_vec_reg <= mivp_pkg::MIVP_VBASE_RST;
    end
    else
    begin
      irq_req_reg <= win_found; // R18
      irq_idx_reg <= win_idx;
      irq_num_reg <= mivp_pkg::MIVP_SRC_NUM[win_idx]; // R04 R05 R06 R23
      irq_lvl_reg <= win_lvl; // R23
      irq_vec_reg <= mivp_pkg::mivp_vec_addr(vbase_reg, mivp_pkg::MIVP_SRC_NUM[win_idx]); // R01 R02 R03
    end
  end

  // ----------------------------------------------------------------
  // software and break vectors
  // ----------------------------------------------------------------
  // instruction interrupts bypass enable, flags and priority entirely
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sw_valid_reg <= 1'b0;
      sw_vec_reg <= mivp_pkg::MIVP_VBASE_RST;
    end
    else
    begin
      sw_valid_reg <= sw_int; // R08 R09
      // vector held between instructions so the core may fetch it late
      if (sw_int)
        sw_vec_reg <= mivp_pkg::mivp_vec_addr(vbase_reg, sw_num); // R01 R07
    end
  end

  // ----------------------------------------------------------------
  // base, pin configuration and read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      vbase_reg <= mivp_pkg::MIVP_VBASE_RST;
      pinen_reg <= mivp_pkg::MIVP_PINEN_RST;
    end
    else
    begin
      if (wr_vb0)
        vbase_reg[7:0] <= bus.wdata; // R02
      if (wr_vb1)
        vbase_reg[15:8] <= bus.wdata;
      if (wr_vb2)
        vbase_reg[19:16] <= bus.wdata[3:0];
      if (wr_pinen)
        pinen_reg <= bus.wdata;
    end
  end

  always_comb
  begin
    rd_mux = 8'h00;
    for (int k = 0; k < NSRC; k++)
    begin
      if (rd_sel[k])
        rd_mux = src_byte[k];
    end
    if (bus.rd && (bus.addr == mivp_pkg::MIVP_OFF_VBASE0))
      rd_mux = vbase_reg[7:0];
    if (bus.rd && (bus.addr == mivp_pkg::MIVP_OFF_VBASE1))
      rd_mux = vbase_reg[15:8];
    if (bus.rd && (bus.addr == mivp_pkg::MIVP_OFF_VBASE2))
      rd_mux = {4'h0, vbase_reg[19:16]};
    if (bus.rd && (bus.addr == mivp_pkg::MIVP_OFF_PINEN))
      rd_mux = pinen_reg;
  end

  // unmapped reads and idle cycles return zero
  always_ff @(posedge clk)
  begin
    if (reset)
      rd_data_reg <= 8'h00;
    else
      rd_data_reg <= bus.rd ? rd_mux : 8'h00;
  end

  assign rd_data = rd_data_reg;
  assign irq_o = '{req: irq_req_reg, num: irq_num_reg, level: irq_lvl_reg, vector: irq_vec_reg};
  assign sw_vec_o = '{valid: sw_valid_reg, vector: sw_vec_reg};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_accept_gate: assert property (irq_o.req |-> $past(cpu_i_flag) && (irq_o.level > $past(cpu_ipl))) // R18
    else $error("request shown without acceptance");
  a_global_off: assert property (!cpu_i_flag |=> !irq_o.req) // R15
    else $error("request shown with global enable low");
  a_ipl_blocks: assert property (cpu_ipl == 3'h7 |=> !irq_o.req) // R21
    else $error("priority seven did not block");
  a_level_zero: assert property (irq_o.req |-> irq_o.level != 3'h0) // R20
    else $error("level zero source accepted");
  a_vector_calc: assert property (irq_o.req |-> // R01 R02 R03
    irq_o.vector == $past(vbase_reg) + {12'h000, irq_o.num, 2'b00})
    else $error("vector address wrong");
  a_sw_vector: assert property (sw_int |=> sw_vec_o.valid && // R07 R08
    sw_vec_o.vector == $past(vbase_reg) + {12'h000, $past(sw_num), 2'b00})
    else $error("software vector wrong");
  a_sw_source: assert property (sw_vec_o.valid |-> $past(sw_int)) // R08
    else $error("software vector without instruction");
  a_sw_vec_hold: assert property (!sw_int |=> sw_vec_o.vector == $past(sw_vec_o.vector)) // R07
    else $error("software vector moved between instructions");
  a_num_range: assert property (irq_o.req |-> irq_o.num != 6'h00 && irq_o.num < 6'h20) // R07
    else $error("maskable number outside peripheral range");
  a_rd_unmapped: assert property (bus.rd && !(|rd_sel) && bus.addr[7:2] != 6'h18 |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_rd_idle: assert property (!bus.rd |=> rd_data == 8'h00)
    else $error("read data outside its cycle");
  a_vbase_hold: assert property (!wr_vb0 && !wr_vb1 && !wr_vb2 |=> vbase_reg == $past(vbase_reg)) // R19
    else $error("vector base changed without a write");
  a_no_double: assert property (irq_taken && !src_set[irq_idx_reg] |=> // R16
    !(irq_o.req && irq_idx_reg == $past(irq_idx_reg)))
    else $error("acknowledged source shown again");

  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  c_ack: cover property (irq_taken);
  c_sw_int: cover property (sw_int && !cpu_i_flag ##1 sw_vec_o.valid);
  c_sw_break: cover property (sw_int && sw_num == 6'h00);
  c_tie: cover property (eligible[3] && eligible[4] && lvl_next[3] == lvl_next[4]);
  c_pin_req: cover property (|pin_pulse ##1 irq_o.req);

endmodule : mivp_irq_ctrl

// [test/mivp_cpu_model.sv]
// core-side model that acknowledges the presented maskable request
`timescale 1ns/1ns
module mivp_cpu_model (
  input wire logic clk,
  input wire logic reset,
  input mivp_pkg::mivp_irq_t irq,
  input wire logic ack_en,
  input wire logic [3:0] ack_wait,
  output logic cpu_ack,
  output logic [5:0] taken_num
);
  // ----------------------------------------------------------------
  // acknowledge
  // ----------------------------------------------------------------
  logic [3:0] wait_reg;
  logic ack_reg;
  logic [5:0] num_reg;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ack_reg <= 1'b0;
      wait_reg <= 4'h0;
      num_reg <= 6'h00;
    end
    else if (ack_reg)
    begin
      // single-cycle pulse so one acknowledge clears exactly one winner
      ack_reg <= 1'b0;
      wait_reg <= 4'h0;
    end
    else if (ack_en && irq.req)
    begin
      if (wait_reg >= ack_wait)
      begin
        ack_reg <= 1'b1;
        num_reg <= irq.num;
      end
      else
        wait_reg <= wait_reg + 4'h1;
    end
    else
      wait_reg <= 4'h0;
  end

  assign cpu_ack = ack_reg;
  assign taken_num = num_reg;
endmodule : mivp_cpu_model

// [test/test_mivp_irq_ctrl.sv]
// self-checking bench for the maskable interrupt controller
`timescale 1ns/1ns
module test_mivp_irq_ctrl;
  typedef struct packed {
    logic [4:0] idx;
    logic [5:0] num;
    logic [2:0] lvl;
    logic [2:0] processor_priority_level;
    logic ien;
    logic acc;
  } mivp_row_t;
  // offset add must carry past the low byte of the base
  localparam logic [19:0] BASE = 20'h12fc0;
  logic clk = 1'b0;
  logic reset = 1'b1;
  mivp_pkg::mivp_bus_t bus = '0;
  logic [7:0] rd_data;
  logic [17:0] periph_req = 18'h00000;
  logic [3:0] pin_in = 4'h0;
  logic cpu_i_flag = 1'b0;
  logic [2:0] cpu_ipl = 3'h0;
  logic cpu_ack;
  logic sw_int = 1'b0;
  logic [5:0] sw_num = 6'h00;
  mivp_pkg::mivp_irq_t irq_o;
  mivp_pkg::mivp_swv_t sw_vec_o;
  logic ack_en = 1'b0;
  logic [3:0] ack_wait = 4'h0;
  logic [5:0] taken_num;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [5:0] swn [0:2] = '{6'h00, 6'h20, 6'h3f};
  mivp_row_t rows [0:14] = '{
    '{5'h00, 6'h01, 3'h7, 3'h6, 1'h1, 1'h1},
    '{5'h01, 6'h02, 3'h1, 3'h0, 1'h1, 1'h1},
    '{5'h02, 6'h0a, 3'h3, 3'h0, 1'h1, 1'h1},
    '{5'h03, 6'h0b, 3'h2, 3'h1, 1'h1, 1'h1},
    '{5'h05, 6'h0d, 3'h5, 3'h4, 1'h1, 1'h1},
    '{5'h06, 6'h10, 3'h6, 3'h5, 1'h1, 1'h1},
    '{5'h07, 6'h11, 3'h3, 3'h2, 1'h1, 1'h1},
    '{5'h0a, 6'h16, 3'h2, 3'h0, 1'h1, 1'h1},
    '{5'h0b, 6'h18, 3'h7, 3'h0, 1'h1, 1'h1},
    '{5'h0e, 6'h1c, 3'h5, 3'h0, 1'h1, 1'h1},
    '{5'h11, 6'h1f, 3'h6, 3'h0, 1'h1, 1'h1},
    '{5'h02, 6'h0a, 3'h0, 3'h0, 1'h1, 1'h0},
    '{5'h03, 6'h0b, 3'h3, 3'h3, 1'h1, 1'h0},
    '{5'h05, 6'h0d, 3'h7, 3'h7, 1'h1, 1'h0},
    '{5'h06, 6'h10, 3'h7, 3'h0, 1'h0, 1'h0}};

  mivp_irq_ctrl u_mivp_irq_ctrl (.clk(clk), .reset(reset), .bus(bus), .rd_data(rd_data),
    .periph_req(periph_req), .pin_in(pin_in), .cpu_i_flag(cpu_i_flag), .cpu_ipl(cpu_ipl),
    .cpu_ack(cpu_ack), .sw_int(sw_int), .sw_num(sw_num), .irq_o(irq_o), .sw_vec_o(sw_vec_o));
  mivp_cpu_model u_mivp_cpu_model (.clk(clk), .reset(reset), .irq(irq_o), .ack_en(ack_en),
    .ack_wait(ack_wait), .cpu_ack(cpu_ack), .taken_num(taken_num));

  always #4 clk = ~clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic chk_val(input logic [19:0] got, input logic [19:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    chk_val(20'(rd_data), 20'(exp), "read data");
  endtask : rd_reg

  task automatic pulse(input logic [17:0] bits);
    @(posedge clk);
    periph_req <= bits;
    @(posedge clk);
    periph_req <= 18'h00000;
    #1;
  endtask : pulse

  // lets the core model acknowledge, then samples just after the edge that ends the acknowledge pulse
  task automatic take(input logic [5:0] num);
    int k;
    ack_en <= 1'b1;
    for (k = 0; k < 20 && cpu_ack !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    chk_val(20'(cpu_ack), 20'h1, "ack raised");
    @(posedge clk);
    ack_en <= 1'b0;
    #1;
    chk_val(20'(taken_num), 20'(num), "acked number");
  endtask : take

  // waits a bounded number of cycles for a request to show
  task automatic wait_req();
    int k;
    for (k = 0; k < 10 && irq_o.req !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
  endtask : wait_req

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  initial
  begin
    int i;
    mivp_row_t r;
    logic [7:0] off;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd_reg(8'h60, 8'h00);
    rd_reg(8'h55, 8'h00);
    rd_reg(8'h4e, 8'h00);
    wr_reg(8'h60, BASE[7:0]);
    wr_reg(8'h61, BASE[15:8]);
    wr_reg(8'h62, {4'h0, BASE[19:16]});
    for (i = 0; i < 15; i++)
    begin
      r = rows[i];
      off = mivp_pkg::MIVP_SRC_OFF[r.idx];
      wr_reg(off, {5'h00, r.lvl});
      cpu_ipl <= r.processor_priority_level;
      cpu_i_flag <= r.ien;
      ack_wait <= 4'(i % 4);
      pulse(18'h00001 << r.idx);
      chk_val(20'(irq_o.req), 20'(r.acc), "accept");
      if (r.acc)
      begin
        chk_val(20'(irq_o.num), 20'(r.num), "number");
        chk_val(20'(irq_o.level), 20'(r.lvl), "level");
        chk_val(irq_o.vector, BASE + 20'({r.num, 2'h0}), "vector");
        take(r.num);
        chk_val(20'(irq_o.req), 20'h0, "after ack");
        rd_reg(off, {5'h00, r.lvl});
      end
      else
      begin
        rd_reg(off, {5'h01, r.lvl});
        wr_reg(off, {5'h00, r.lvl});
        rd_reg(off, {5'h00, r.lvl});
      end
    end
    wr_reg(8'h43, 8'h04);
    wr_reg(8'h44, 8'h04);
    cpu_ipl <= 3'h0;
    cpu_i_flag <= 1'b1;
    pulse(18'h00018);
    chk_val(20'(irq_o.num), 20'h0b, "tie winner");
    take(6'h0b);
    @(posedge clk);
    #1;
    chk_val(20'(irq_o.num), 20'h0c, "tie second");
    take(6'h0c);
    wr_reg(8'h40, 8'h02);
    wr_reg(8'h4d, 8'h06);
    pulse(18'h20001);
    chk_val(20'(irq_o.num), 20'h1f, "higher level");
    take(6'h1f);
    take(6'h01);
    wr_reg(8'h42, 8'h0d);
    rd_reg(8'h42, 8'h05);
    chk_val(20'(irq_o.req), 20'h0, "flag write one");
    for (i = 0; i < 3; i++)
    begin
      @(posedge clk);
      sw_int <= 1'b1;
      sw_num <= swn[i];
      cpu_i_flag <= 1'b0;
      cpu_ipl <= 3'h7;
      @(posedge clk);
      sw_int <= 1'b0;
      #1;
      chk_val(20'(sw_vec_o.valid), 20'h1, "sw valid");
      chk_val(sw_vec_o.vector, BASE + 20'({swn[i], 2'h0}), "sw vector");
      @(posedge clk);
      #1;
      chk_val(20'(sw_vec_o.valid), 20'h0, "sw pulse");
    end
    wr_reg(8'h5d, 8'h13);
    wr_reg(8'h63, 8'h01);
    cpu_i_flag <= 1'b1;
    cpu_ipl <= 3'h0;
    rd_reg(8'h5d, 8'h13);
    @(posedge clk);
    pin_in <= 4'h1;
    wait_req();
    chk_val(20'(irq_o.num), 20'h1d, "pin number");
    chk_val(irq_o.vector, BASE + 20'h00074, "pin vector");
    take(6'h1d);
    @(posedge clk);
    pin_in <= 4'h0;
    repeat (8) @(posedge clk);
    #1;
    chk_val(20'(irq_o.req), 20'h0, "falling ignored");
    wr_reg(8'h59, 8'he0);
    rd_reg(8'h59, 8'h00);
    // both-edge mode on pin 4 with polarity left at falling
    wr_reg(8'h5e, 8'h04);
    wr_reg(8'h63, 8'h88);
    @(posedge clk);
    pin_in <= 4'h8;
    wait_req();
    chk_val(20'(irq_o.num), 20'h1e, "both rising");
    take(6'h1e);
    @(posedge clk);
    pin_in <= 4'h0;
    wait_req();
    chk_val(20'(irq_o.num), 20'h1e, "both falling");
    take(6'h1e);
    // reset in mid-run drops a pending request and every register
    pulse(18'h20000);
    chk_val(20'(irq_o.req), 20'h1, "before reset");
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk_val(20'(irq_o.req), 20'h0, "reset request");
    chk_val(sw_vec_o.vector, 20'h00000, "reset sw vector");
    rd_reg(8'h4d, 8'h00);
    rd_reg(8'h61, 8'h00);
    close_out();
  end
endmodule : test_mivp_irq_ctrl
